// [verilog/rcs_params.svh]
// Offsets, field positions and reset values of the read channel status block.
`ifndef RCS_PARAMS_SVH
`define RCS_PARAMS_SVH

// ----------------------------------------
// Register map
// ----------------------------------------
`define RCS_ADDR_W 8
`define RCS_DATA_W 32
`define RCS_OFF_ENABLE 8'h00
`define RCS_OFF_STATUS 8'h04

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RCS_NFLAGS 3
`define RCS_BIT_CMP 12
`define RCS_BIT_DLY 13
`define RCS_BIT_ERR 14
`define RCS_BIT_RSVD 15
`define RCS_THR_LSB 16
`define RCS_THR_MSB 23
`define RCS_DLY_LSB 24
`define RCS_DLY_MSB 31
`define RCS_CNT_W 8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RCS_THR_RST 8'h01
`define RCS_DLY_RST 8'h00
`define RCS_FLAGS_RST 3'h0
`define RCS_WORD_ZERO 32'h0000_0000

`endif

// [verilog/rcs_pkg.sv]
// Types shared by the read channel status block.
package rcs_pkg;

	// Position of each event inside the flag vector.
	typedef enum logic [1:0] {
		RCS_FLAG_CMP = 2'h0,
		RCS_FLAG_DLY = 2'h1,
		RCS_FLAG_ERR = 2'h2
	} rcs_flag_t;

	// Snapshot of the two read-only count fields.
	typedef struct packed {
		logic [7:0] delay_count;
		logic [7:0] threshold_count;
	} rcs_counts_t;

endpackage : rcs_pkg

// [verilog/rcs_flag_if.sv]
// Carrier between the status top and its sticky flag bank.
`timescale 1ns/1ps
interface rcs_flag_if #(
	parameter int N = 3
);
	logic [N-1:0] set;
	logic [N-1:0] clr;
	logic [N-1:0] flags;

	modport ctrl (output set, output clr, input flags);
	modport bank (input set, input clr, output flags);
endinterface : rcs_flag_if

// [verilog/rcs_flag_bank.sv]
// Bank of sticky event flags, cleared by writing one, where a set beats a clear.
`timescale 1ns/1ps
`include "rcs_params.svh"
module rcs_flag_bank #(
	parameter int N = 3
) (
	input wire logic clk,
	input wire logic sys_rst,
	rcs_flag_if.bank fb
);

	// ----------------------------------------
	// One sticky bit per event
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < N; i++) begin : g_flag
			// A set arriving with a clear keeps the flag, so no event is lost.
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					fb.flags[i] <= 1'b0;
				end else if (fb.set[i]) begin
					fb.flags[i] <= 1'b1;
				end else if (fb.clr[i]) begin
					fb.flags[i] <= 1'b0;
				end
			end
		end
	endgenerate

endmodule : rcs_flag_bank

// [verilog/rcs_status.sv]
// Interrupt status half of the read channel status register, with enables and interrupt.
// Functional notes
// - Descriptor mode: completion flag sets when a descriptor with end-of-frame finishes.
// - Simple mode: completion flag sets when a packet transfer fully completes.
// - Completion interrupts only when its enable is one and threshold is reached.
// - Delay-timeout flag, bit 13, sets whenever the delay timer expires.
// - Delay flag set with its enable one drives the interrupt.
// - Error flag, bit 14, sets on error; with enable it drives interrupt.
// - Bit 15 is reserved and always reads zero.
// - Bits 23 to 16 report threshold count, read only, reset to one.
// - Bits 31 to 24 report delay count, read only, reset to zero.
// - Without descriptor support both count fields stay at zero.
// - Writing one clears a flag; writing zero leaves it unchanged.
// - Writes leave the reserved bit and both count fields untouched.
`timescale 1ns/1ps
`include "rcs_params.svh"
module rcs_status #(
	parameter bit descriptor_support_param = 1'b1
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic [`RCS_ADDR_W-1:0] reg_addr,
	input wire logic [`RCS_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [`RCS_DATA_W-1:0] reg_rdata,
	input wire logic desc_done,
	input wire logic desc_eof,
	input wire logic pkt_done,
	input wire logic delay_expired,
	input wire logic error_detect,
	input wire logic threshold_met,
	input wire logic [`RCS_CNT_W-1:0] threshold_count_in,
	input wire logic [`RCS_CNT_W-1:0] delay_count_in,
	output logic irq
);

	// ----------------------------------------
	// Flag bank
	// ----------------------------------------
	rcs_flag_if #(.N(`RCS_NFLAGS)) fl ();

	rcs_flag_bank #(.N(`RCS_NFLAGS)) u_bank (
		.clk(clk),
		.sys_rst(sys_rst),
		.fb(fl.bank)
	);

	logic completion_event_flag;
	logic delay_event_flag;
	logic error_event_flag;
	logic completion_interrupt_enable;
	logic delay_interrupt_enable;
	logic error_interrupt_enable;
	logic cmp_event;
	logic wr_status;
	logic wr_enable;
	logic next_irq;
	rcs_pkg::rcs_counts_t counts;
	logic [`RCS_DATA_W-1:0] status_word;
	logic [`RCS_DATA_W-1:0] enable_word;
	logic [`RCS_DATA_W-1:0] next_rdata;

	assign completion_event_flag = fl.flags[rcs_pkg::RCS_FLAG_CMP];
	assign delay_event_flag = fl.flags[rcs_pkg::RCS_FLAG_DLY];
	assign error_event_flag = fl.flags[rcs_pkg::RCS_FLAG_ERR];

	// ----------------------------------------
	// Event sources
	// ----------------------------------------
	// The completion source depends on how the channel was built.
	always_comb begin
		if (descriptor_support_param) begin
			cmp_event = desc_done & desc_eof;
		end else begin
			cmp_event = pkt_done;
		end
	end

	// Event pulses feed the set side of the bank.
	always_comb begin
		fl.set = '0;
		fl.set[rcs_pkg::RCS_FLAG_CMP] = cmp_event;
		fl.set[rcs_pkg::RCS_FLAG_DLY] = delay_expired;
		fl.set[rcs_pkg::RCS_FLAG_ERR] = error_detect;
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	assign wr_status = reg_wr && (reg_addr == `RCS_OFF_STATUS);
	assign wr_enable = reg_wr && (reg_addr == `RCS_OFF_ENABLE);

	// A one in a flag position clears it; zeros and other bits do nothing.
	always_comb begin
		fl.clr = '0;
		if (wr_status) begin
			fl.clr[rcs_pkg::RCS_FLAG_CMP] = reg_wdata[`RCS_BIT_CMP];
			fl.clr[rcs_pkg::RCS_FLAG_DLY] = reg_wdata[`RCS_BIT_DLY];
			fl.clr[rcs_pkg::RCS_FLAG_ERR] = reg_wdata[`RCS_BIT_ERR];
		end
	end

	// Enables share the flag layout so software can reuse one mask word.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			completion_interrupt_enable <= 1'b0;
			delay_interrupt_enable <= 1'b0;
			error_interrupt_enable <= 1'b0;
		end else if (wr_enable) begin
			completion_interrupt_enable <= reg_wdata[`RCS_BIT_CMP];
			delay_interrupt_enable <= reg_wdata[`RCS_BIT_DLY];
			error_interrupt_enable <= reg_wdata[`RCS_BIT_ERR];
		end
	end

	// ----------------------------------------
	// Count status fields
	// ----------------------------------------
	// Counts follow the counters only; no bus write reaches them.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			// A simple build must read zero even straight after reset, so the reset value is gated too.
			counts.threshold_count <= descriptor_support_param ? `RCS_THR_RST : '0;
			counts.delay_count <= descriptor_support_param ? `RCS_DLY_RST : '0;
		end else if (descriptor_support_param) begin
			counts.threshold_count <= threshold_count_in;
			counts.delay_count <= delay_count_in;
		end else begin
			counts.threshold_count <= '0;
			counts.delay_count <= '0;
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	// Low status bits belong to other logic and read as zero here.
	always_comb begin
		status_word = `RCS_WORD_ZERO;
		status_word[`RCS_BIT_CMP] = completion_event_flag;
		status_word[`RCS_BIT_DLY] = delay_event_flag;
		status_word[`RCS_BIT_ERR] = error_event_flag;
		status_word[`RCS_BIT_RSVD] = 1'b0;
		status_word[`RCS_THR_MSB:`RCS_THR_LSB] = counts.threshold_count;
		status_word[`RCS_DLY_MSB:`RCS_DLY_LSB] = counts.delay_count;
	end

	// The enable word shows only the three enable bits.
	always_comb begin
		enable_word = `RCS_WORD_ZERO;
		enable_word[`RCS_BIT_CMP] = completion_interrupt_enable;
		enable_word[`RCS_BIT_DLY] = delay_interrupt_enable;
		enable_word[`RCS_BIT_ERR] = error_interrupt_enable;
	end

	// Unmapped addresses answer zero rather than stalling the master.
	always_comb begin
		next_rdata = `RCS_WORD_ZERO;
		if (reg_rd) begin
			case (reg_addr)
				`RCS_OFF_STATUS: next_rdata = status_word;
				`RCS_OFF_ENABLE: next_rdata = enable_word;
				default: next_rdata = `RCS_WORD_ZERO;
			endcase
		end
	end

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			reg_rdata <= `RCS_WORD_ZERO;
		end else begin
			reg_rdata <= next_rdata;
		end
	end

	// ----------------------------------------
	// Interrupt output
	// ----------------------------------------
	// Completion also waits for the threshold, so bursts of small packets coalesce.
	always_comb begin
		next_irq = (completion_event_flag & completion_interrupt_enable & threshold_met)
			| (delay_event_flag & delay_interrupt_enable)
			| (error_event_flag & error_interrupt_enable);
	end

	// Registered for a clean level; it lags the flags by one cycle.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	// Descriptor end with end-of-frame raises completion next cycle.
	a_cmp_desc_set:
	assert property (descriptor_support_param && desc_done && desc_eof |=> completion_event_flag)
	else $error("completion flag not set after end-of-frame descriptor");

	// Packet done raises completion in simple mode.
	a_cmp_pkt_set:
	assert property (!descriptor_support_param && pkt_done |=> completion_event_flag)
	else $error("completion flag not set after packet done");

	// Completion alone without threshold keeps the line low.
	a_cmp_irq_gate:
	assert property (!(delay_event_flag && delay_interrupt_enable)
		&& !(error_event_flag && error_interrupt_enable)
		&& !(completion_event_flag && completion_interrupt_enable && threshold_met) |=> !irq)
	else $error("interrupt raised without a qualified source");

	// Completion with enable and threshold raises the line.
	a_cmp_irq_rise:
	assert property (completion_event_flag && completion_interrupt_enable && threshold_met |=> irq)
	else $error("completion interrupt missing");

	// Timer expiry sets the delay flag, visible at bit 13 on a read.
	a_dly_set_read:
	assert property (delay_expired ##1 (reg_rd && reg_addr == `RCS_OFF_STATUS)
		|=> reg_rdata[`RCS_BIT_DLY])
	else $error("delay flag not reported after timer expiry");

	// Enabled delay flag drives the interrupt.
	a_dly_irq_level:
	assert property (delay_event_flag && delay_interrupt_enable |=> irq)
	else $error("delay interrupt missing");

	// Error sets the flag and, when enabled, the interrupt two cycles on.
	a_err_set_irq:
	assert property (error_detect && error_interrupt_enable && !wr_enable |=> error_event_flag ##1 irq)
	else $error("error flag or interrupt missing");

	// The reserved bit never reads as one.
	a_rsvd_reads_zero:
	assert property (reg_rd |=> !reg_rdata[`RCS_BIT_RSVD])
	else $error("reserved status bit read as one");

	// Threshold field reads back the captured count.
	a_thr_field_read:
	assert property (reg_rd && reg_addr == `RCS_OFF_STATUS
		|=> reg_rdata[`RCS_THR_MSB:`RCS_THR_LSB] == $past(counts.threshold_count))
	else $error("threshold field mismatch on read");

	// Delay field reads back the captured count.
	a_dly_field_read:
	assert property (reg_rd && reg_addr == `RCS_OFF_STATUS
		|=> reg_rdata[`RCS_DLY_MSB:`RCS_DLY_LSB] == $past(counts.delay_count))
	else $error("delay field mismatch on read");

	// Simple builds hold both count fields at zero.
	a_counts_fixed_zero:
	assert property (!descriptor_support_param |-> counts == '0)
	else $error("count fields nonzero without descriptor support");

	// A one clears the error flag when no new error arrives.
	a_w1c_clears:
	assert property (wr_status && reg_wdata[`RCS_BIT_ERR] && !error_detect |=> !error_event_flag)
	else $error("write one did not clear error flag");

	// A zero leaves a set delay flag alone.
	a_w0_keeps:
	assert property (wr_status && delay_event_flag && !reg_wdata[`RCS_BIT_DLY] |=> delay_event_flag)
	else $error("write zero changed delay flag");

	// A status write cannot steer the threshold count field.
	a_counts_ignore_write:
	assert property (wr_status && descriptor_support_param
		|=> counts.threshold_count == $past(threshold_count_in))
	else $error("status write disturbed threshold field");

	// With no flag set the interrupt is low one cycle later.
	a_irq_drops:
	assert property (!completion_event_flag && !delay_event_flag && !error_event_flag |=> !irq)
	else $error("interrupt stuck with all flags clear");

endmodule : rcs_status

// [bench/rcs_status_tb.sv]
// Self-checking testbench of the read channel status block in both build modes.
`timescale 1ns/1ps
`include "rcs_params.svh"
module rcs_status_tb;
	localparam int LIMIT = 6000;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic desc_done = 1'b0, desc_eof = 1'b0, pkt_done = 1'b0;
	logic delay_expired = 1'b0, error_detect = 1'b0, threshold_met = 1'b0;
	logic [7:0] threshold_count_in = 8'h00, delay_count_in = 8'h00;
	logic [31:0] rdata1, rdata0, m_rd1, m_rd0;
	logic irq1, irq0, m_irq1, m_irq0;
	logic [2:0] m_flg1, m_flg0, m_en, clr_vec;
	logic [15:0] m_cnt;
	logic run_checks = 1'b0;
	int fails = 0;
	int checks = 0;
	int cycles = 0;

	// --------------------------------------------------------
	// Clock, instances and the reference model
	// --------------------------------------------------------
	// The clock toggles every half period of 2.5 ns.
	initial begin
		forever #2.5 clk = ~clk;
	end

	// Both builds share every input so their answers can be told apart.
	rcs_status #(.descriptor_support_param(1'b1)) dut_u (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata1), .desc_done(desc_done),
		.desc_eof(desc_eof), .pkt_done(pkt_done), .delay_expired(delay_expired), .error_detect(error_detect),
		.threshold_met(threshold_met), .threshold_count_in(threshold_count_in),
		.delay_count_in(delay_count_in), .irq(irq1));
	rcs_status #(.descriptor_support_param(1'b0)) dut_simple_u (.clk(clk), .sys_rst(sys_rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata0),
		.desc_done(desc_done), .desc_eof(desc_eof), .pkt_done(pkt_done), .delay_expired(delay_expired),
		.error_detect(error_detect), .threshold_met(threshold_met),
		.threshold_count_in(threshold_count_in), .delay_count_in(delay_count_in), .irq(irq0));

	// Status word as software should see it; the simple build keeps both counts at zero.
	function automatic logic [31:0] status_word(input logic [2:0] flg, input logic [15:0] cnt);
		return {cnt, 1'b0, flg, 12'h000};
	endfunction : status_word

	// Read answer for the current strobe, zero outside a read.
	function automatic logic [31:0] read_word(input logic [2:0] flg, input logic [15:0] cnt);
		if (!reg_rd)
			return 32'h0000_0000;
		if (reg_addr == `RCS_OFF_STATUS)
			return status_word(flg, cnt);
		if (reg_addr == `RCS_OFF_ENABLE)
			return {17'h00000, m_en, 12'h000};
		return 32'h0000_0000;
	endfunction : read_word

	assign clr_vec = (reg_wr && reg_addr == `RCS_OFF_STATUS) ? reg_wdata[14:12] : 3'h0;

	// A hung run counts as a mismatch and goes straight to the verdict.
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			fails++;
			complete_run();
		end
	end

	// The model samples the same edge as the design, so a set beats a same-cycle clear.
	always @(posedge clk) begin
		if (sys_rst) begin
			{m_flg1, m_flg0, m_en} <= 9'h000;
			{m_irq1, m_irq0} <= 2'h0;
			{m_rd1, m_rd0} <= 64'h0;
			m_cnt <= {`RCS_DLY_RST, `RCS_THR_RST};
		end else begin
			m_irq1 <= |(m_flg1 & m_en & {2'h3, threshold_met});
			m_irq0 <= |(m_flg0 & m_en & {2'h3, threshold_met});
			m_flg1 <= (m_flg1 & ~clr_vec) | {error_detect, delay_expired, desc_done & desc_eof};
			m_flg0 <= (m_flg0 & ~clr_vec) | {error_detect, delay_expired, pkt_done};
			m_rd1 <= read_word(m_flg1, m_cnt);
			m_rd0 <= read_word(m_flg0, 16'h0000);
			m_cnt <= {delay_count_in, threshold_count_in};
			if (reg_wr && reg_addr == `RCS_OFF_ENABLE)
				m_en <= reg_wdata[14:12];
		end
	end

	// --------------------------------------------------------
	// Compare tasks and closing
	// --------------------------------------------------------
	task automatic check_word(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", name, exp, got);
		end
	endtask : check_word

	task automatic check_bit(input string name, input logic exp, input logic got);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s expected %b seen %b", name, exp, got);
		end
	endtask : check_bit

	task automatic complete_run();
		if (fails == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : complete_run

	// Outputs are compared at the falling edge, long after the rising edge updates have landed.
	always @(negedge clk) begin
		if (run_checks) begin
			check_word("rdata_desc", m_rd1, rdata1);
			check_word("rdata_simple", m_rd0, rdata0);
			check_bit("irq_desc", m_irq1, irq1);
			check_bit("irq_simple", m_irq0, irq0);
		end
	end

	// --------------------------------------------------------
	// Stimulus
	// --------------------------------------------------------
	// One random cycle: exclusive strobes, sparse event pulses and a stray address now and then.
	task automatic drive_random();
		logic [31:0] r;
		r = $urandom;
		@(posedge clk);
		reg_rd <= r[0];
		reg_wr <= r[1] & ~r[0];
		reg_addr <= (r[3:2] == 2'h0) ? 8'($urandom) : r[3] ? `RCS_OFF_STATUS : `RCS_OFF_ENABLE;
		reg_wdata <= $urandom;
		desc_done <= (r[6:4] == 3'h0);
		desc_eof <= r[7];
		pkt_done <= (r[10:8] == 3'h0);
		delay_expired <= (r[13:11] == 3'h0);
		error_detect <= (r[16:14] == 3'h0);
		threshold_met <= r[17];
		threshold_count_in <= r[25:18];
		delay_count_in <= 8'($urandom);
	endtask : drive_random

	// Reset is held and released on the rising edge, then the status word is read one cycle later.
	task automatic do_reset(input int n);
		@(posedge clk);
		sys_rst <= 1'b1;
		{reg_rd, reg_wr} <= 2'h0;
		repeat (n) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= `RCS_OFF_STATUS;
	endtask : do_reset

	initial begin
		void'($urandom(32'ha56b82de));
		repeat (2) @(posedge clk);
		run_checks <= 1'b1;
		do_reset(12);
		// Delay expiry beside a write-one clear of the same flag, then all enables on.
		@(posedge clk);
		reg_rd <= 1'b0;
		delay_expired <= 1'b1;
		reg_wr <= 1'b1;
		reg_wdata <= 32'hFFFF_FFFF;
		@(posedge clk);
		delay_expired <= 1'b0;
		reg_addr <= `RCS_OFF_ENABLE;
		repeat (3000) drive_random();
		do_reset(2);
		repeat (1500) drive_random();
		complete_run();
	end
endmodule : rcs_status_tb
